// [hdl/tm2_timer.sv]
// Purpose: timer2 control, 16-bit/split counting, capture and interrupt
// Assumes: register strobes one cycle, read data one cycle later
// Notes: count_tick_i paces the counter; tie high to count every clock
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module tm2_timer (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [tm2_pkg::ADDR_W-1:0] addr_i,
  input wire logic [tm2_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic count_tick_i,
  input wire logic capture_input_pin_i,
  output logic [tm2_pkg::DATA_W-1:0] rd_data_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // exact match only: an alias would let a stray write move a counter
  function automatic logic reg_hit(
    input logic [tm2_pkg::ADDR_W-1:0] addr,
    input logic [tm2_pkg::ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction

  // status and mask share one layout, padded with zeros to a byte
  function automatic logic [tm2_pkg::DATA_W-1:0] irq_byte(
    input logic [tm2_pkg::IRQ_W-1:0] bits
  );
    logic [tm2_pkg::DATA_W-1:0] padded;
    padded = tm2_pkg::BYTE_RST;
    padded[tm2_pkg::IRQ_W-1:0] = bits;
    return padded;
  endfunction

  // a wrap in the same cycle as a clearing write must not be lost
  function automatic logic flag_next(
    input logic flag,
    input logic set,
    input logic wr,
    input logic wr_bit
  );
    logic result;
    result = wr ? wr_bit : flag;
    if (set) begin
      result = 1'b1;
    end
    return result;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_control;
  logic wr_reload_lo;
  logic wr_reload_hi;
  logic wr_mask;
  logic wr_config;
  logic rd_status;
  logic [1:0] wr_count;

  assign wr_control = wr_i && reg_hit(addr_i, tm2_pkg::OFS_CONTROL);
  assign wr_count[0] = wr_i && reg_hit(addr_i, tm2_pkg::OFS_COUNT_LO);
  assign wr_count[1] = wr_i && reg_hit(addr_i, tm2_pkg::OFS_COUNT_HI);
  assign wr_reload_lo = wr_i && reg_hit(addr_i, tm2_pkg::OFS_RELOAD_LO);
  assign wr_reload_hi = wr_i && reg_hit(addr_i, tm2_pkg::OFS_RELOAD_HI);
  assign wr_mask = wr_i && reg_hit(addr_i, tm2_pkg::OFS_IRQ_MASK);
  assign wr_config = wr_i && reg_hit(addr_i, tm2_pkg::OFS_IRQ_CONFIG);
  assign rd_status = rd_i && reg_hit(addr_i, tm2_pkg::OFS_IRQ_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic high_overflow_flag_ff;
  logic low_overflow_flag_ff;
  logic low_overflow_irq_enable_ff;
  logic capture_enable_ff;
  logic split_mode_select_ff;
  logic run_control_ff;
  logic clock_select_ff;
  logic timer_irq_enable_ff;
  logic [7:0] reload_low_byte_ff;
  logic [7:0] reload_high_byte_ff;
  logic [tm2_pkg::IRQ_W-1:0] irq_status_ff;
  logic [tm2_pkg::IRQ_W-1:0] irq_mask_ff;
  logic capture_pin_prev_ff;
  logic [7:0] rd_data_ff;
  logic irq_ff;

  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [1:0] byte_inc;
  logic [1:0] byte_wrap_load;
  logic [1:0] byte_wrap;
  logic [7:0] byte_count [2];
  logic [7:0] byte_reload [2];
  logic capture_fall;
  logic capture_event;
  logic [tm2_pkg::IRQ_W-1:0] irq_events;
  logic [7:0] control_view;

  ////////////////////////////////////////////////////////////////////////
  // count path

  // split: low byte free-running, run gates high byte only; 16-bit:
  // run gates the low byte and the high byte takes the low byte carry
  always_comb begin
    if (split_mode_select_ff) begin
      byte_inc[0] = count_tick_i;
      byte_inc[1] = count_tick_i && run_control_ff;
      byte_wrap_load[0] = 1'b1;
    end else begin
      byte_inc[0] = count_tick_i && run_control_ff;
      byte_inc[1] = byte_wrap[0];
      // low byte reloads only when the whole 16-bit count overflows
      byte_wrap_load[0] = (byte_count[1] == tm2_pkg::BYTE_MAX);
    end
    byte_wrap_load[1] = 1'b1;
  end

  assign byte_reload[0] = reload_low_byte_ff;
  assign byte_reload[1] = reload_high_byte_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_byte
      tm2_byte_cnt u_byte (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(byte_inc[gi]),
        .wrap_load_i(byte_wrap_load[gi]),
        .reload_i(byte_reload[gi]),
        .wr_i(wr_count[gi]),
        .wr_data_i(wr_data_i),
        .count_o(byte_count[gi]),
        .wrap_o(byte_wrap[gi])
      );
    end
  endgenerate

  assign count_low_byte = byte_count[0];
  assign count_high_byte = byte_count[1];

  ////////////////////////////////////////////////////////////////////////
  // capture edge

  // pin is synchronous already, so one stage is enough for the edge
  assign capture_fall = capture_pin_prev_ff && !capture_input_pin_i;
  assign capture_event = capture_fall && capture_enable_ff
                         && timer_irq_enable_ff;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_pin_prev_ff <= 1'b1;
    end else begin
      capture_pin_prev_ff <= capture_input_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reload registers; a capture beats a software write in one cycle

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload_low_byte_ff <= tm2_pkg::BYTE_RST;
      reload_high_byte_ff <= tm2_pkg::BYTE_RST;
    end else if (capture_event) begin
      reload_low_byte_ff <= count_low_byte;
      reload_high_byte_ff <= count_high_byte;
    end else begin
      if (wr_reload_lo) begin
        reload_low_byte_ff <= wr_data_i;
      end
      if (wr_reload_hi) begin
        reload_high_byte_ff <= wr_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_overflow_irq_enable_ff <= 1'b0;
      capture_enable_ff <= 1'b0;
      split_mode_select_ff <= 1'b0;
      run_control_ff <= 1'b0;
      clock_select_ff <= 1'b0;
    end else if (wr_control) begin
      low_overflow_irq_enable_ff <= wr_data_i[tm2_pkg::BIT_LOW_IRQ_EN];
      capture_enable_ff <= wr_data_i[tm2_pkg::BIT_CAPTURE_EN];
      split_mode_select_ff <= wr_data_i[tm2_pkg::BIT_SPLIT];
      run_control_ff <= wr_data_i[tm2_pkg::BIT_RUN];
      // held for software only; source selection is not built here
      clock_select_ff <= wr_data_i[tm2_pkg::BIT_CLK_SEL];
    end
  end

  // flags: hardware sets, a control write loads the bit (0 clears), set wins
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_overflow_flag_ff <= 1'b0;
    end else begin
      high_overflow_flag_ff <= flag_next(high_overflow_flag_ff,
        byte_wrap[1], wr_control,
        wr_data_i[tm2_pkg::BIT_HIGH_FLAG]);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_overflow_flag_ff <= 1'b0;
    end else begin
      low_overflow_flag_ff <= flag_next(low_overflow_flag_ff,
        byte_wrap[0], wr_control,
        wr_data_i[tm2_pkg::BIT_LOW_FLAG]);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_irq_enable_ff <= 1'b0;
    end else if (wr_config) begin
      timer_irq_enable_ff <= wr_data_i[tm2_pkg::BIT_TIMER_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  always_comb begin
    irq_events = tm2_pkg::IRQ_RST;
    irq_events[tm2_pkg::IRQ_HIGH] = byte_wrap[1];
    irq_events[tm2_pkg::IRQ_LOW] = byte_wrap[0]
                                   && low_overflow_irq_enable_ff;
    irq_events[tm2_pkg::IRQ_CAPTURE] = capture_event;
  end

  // read clears, but an event in the same cycle stays set
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_status_ff <= tm2_pkg::IRQ_RST;
    end else if (rd_status) begin
      irq_status_ff <= irq_events;
    end else begin
      irq_status_ff <= irq_status_ff | irq_events;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask_ff <= tm2_pkg::IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_ff <= wr_data_i[tm2_pkg::IRQ_W-1:0];
    end
  end

  // global enable gates the output, so enabling late still reports overflows; captures need it set
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= timer_irq_enable_ff
                && (|(irq_status_ff & irq_mask_ff));
    end
  end

  assign irq_o = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    control_view = tm2_pkg::CONTROL_RST;
    control_view[tm2_pkg::BIT_HIGH_FLAG] = high_overflow_flag_ff;
    control_view[tm2_pkg::BIT_LOW_FLAG] = low_overflow_flag_ff;
    control_view[tm2_pkg::BIT_LOW_IRQ_EN] = low_overflow_irq_enable_ff;
    control_view[tm2_pkg::BIT_CAPTURE_EN] = capture_enable_ff;
    control_view[tm2_pkg::BIT_SPLIT] = split_mode_select_ff;
    control_view[tm2_pkg::BIT_RUN] = run_control_ff;
    control_view[tm2_pkg::BIT_RESERVED] = 1'b0;
    control_view[tm2_pkg::BIT_CLK_SEL] = clock_select_ff;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_ff <= tm2_pkg::BYTE_RST;
    end else if (rd_i) begin
      unique case (addr_i)
        tm2_pkg::OFS_CONTROL: rd_data_ff <= control_view;
        tm2_pkg::OFS_COUNT_LO: rd_data_ff <= count_low_byte;
        tm2_pkg::OFS_COUNT_HI: rd_data_ff <= count_high_byte;
        tm2_pkg::OFS_RELOAD_LO: rd_data_ff <= reload_low_byte_ff;
        tm2_pkg::OFS_RELOAD_HI: rd_data_ff <= reload_high_byte_ff;
        tm2_pkg::OFS_IRQ_STATUS: rd_data_ff <= irq_byte(irq_status_ff);
        tm2_pkg::OFS_IRQ_MASK: rd_data_ff <= irq_byte(irq_mask_ff);
        tm2_pkg::OFS_IRQ_CONFIG: rd_data_ff <= {7'h00, timer_irq_enable_ff};
        default: rd_data_ff <= tm2_pkg::BYTE_RST;
      endcase
    end else begin
      rd_data_ff <= tm2_pkg::BYTE_RST;
    end
  end

  assign rd_data_o = rd_data_ff;

endmodule

// [inc/tm2_pkg.sv]
// Purpose: constants for the timer2 control and capture block
// Assumes: byte-wide registers on word-aligned offsets of a plain port
// Notes: all offsets, bit positions and reset values live here
//
// What this block does
// - high byte wrap sets high overflow flag
// - 16-bit mode: full wrap sets high flag
// - high flag raises interrupt when enabled
// - flags sticky; only software clears them
// - low byte wrap sets low flag always
// - low overflow interrupts need both enables
// - capture falling edge copies count to reload (needs capture and timer irq enables)
// - split bit picks 16-bit or two 8-bit
// - 16-bit mode: counting only while run bit is set
// - split mode: run gates high byte only
package tm2_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CONFIG = 8'h1C;

  // timer2_control field positions
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_RESERVED = 1;
  localparam int BIT_CLK_SEL = 0;

  // irq status / mask field positions
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW = 1;
  localparam int IRQ_CAPTURE = 2;
  localparam int IRQ_W = 3;

  // irq config field position
  localparam int BIT_TIMER_IRQ_EN = 0;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

endpackage

// [hdl/tm2_byte_cnt.sv]
// Purpose: one 8-bit count byte with wrap detect and reload
// Assumes: software write wins over counting in the same cycle
// Notes: wrap_o is combinational, qualified by inc_i
`timescale 1ns/1ns
module tm2_byte_cnt (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic inc_i,
  input wire logic wrap_load_i,
  input wire logic [7:0] reload_i,
  input wire logic wr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] count_o,
  output logic wrap_o
);

  logic [7:0] count_ff;
  logic [7:0] nxt_count;

  assign wrap_o = inc_i && (count_ff == tm2_pkg::BYTE_MAX);
  assign count_o = count_ff;

  always_comb begin
    nxt_count = count_ff;
    if (wr_i) begin
      nxt_count = wr_data_i;
    end else if (wrap_o) begin
      // reload on wrap, else plain rollover to zero
      nxt_count = wrap_load_i ? reload_i : tm2_pkg::BYTE_RST;
    end else if (inc_i) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_ff <= tm2_pkg::BYTE_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

// [bench/tm2_timer_sva.sv]
// Purpose: port-level checks of the timer2 block
// Assumes: count_tick_i held high by the bench
// Notes: shadows follow software writes and returned read data, never the counter itself
`timescale 1ns/1ns
module tm2_timer_sva (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic count_tick_i,
  input wire logic capture_input_pin_i,
  input wire logic [7:0] rd_data_o,
  input wire logic irq_o
);
  logic rc_ff, rh_ff, hs_ff, ls_ff, en_ff, run_ff, ok_ff;
  logic [2:0] msk_ff;
  logic [7:0] hv_ff;
  wire w_ctl = wr_i && addr_i == tm2_pkg::OFS_CONTROL;
  wire w_hi = wr_i && addr_i == tm2_pkg::OFS_COUNT_HI;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {rc_ff, rh_ff, hs_ff, ls_ff, en_ff, run_ff, ok_ff} <= 7'h00;
      msk_ff <= 3'h0;
      hv_ff <= 8'h00;
    end else begin
      rc_ff <= rd_i && addr_i == tm2_pkg::OFS_CONTROL;
      rh_ff <= rd_i && addr_i == tm2_pkg::OFS_COUNT_HI;
      if (w_ctl) run_ff <= wr_data_i[2];
      if (wr_i && addr_i == tm2_pkg::OFS_IRQ_CONFIG) en_ff <= wr_data_i[0];
      if (wr_i && addr_i == tm2_pkg::OFS_IRQ_MASK) msk_ff <= wr_data_i[2:0];
      hs_ff <= w_ctl ? 1'b0 : hs_ff | (rc_ff & rd_data_o[7]);
      ls_ff <= w_ctl ? 1'b0 : ls_ff | (rc_ff & rd_data_o[6]);
      if (rh_ff) hv_ff <= rd_data_o;
      // any chance of counting voids the remembered high byte
      ok_ff <= (w_ctl && wr_data_i[2]) || run_ff || w_hi ? 1'b0
               : ok_ff | rh_ff;
    end
  end
  ////////////////////////////////////////
  idle_read_zero_a: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside a read");
  reserved_bit_zero_a: assert property (rc_ff |-> !rd_data_o[1])
    else $error("reserved control bit reads one");
  high_sticky_a: assert property (
    rc_ff && hs_ff |-> rd_data_o[7]) else $error("high flag lost");
  low_sticky_a: assert property (
    rc_ff && ls_ff |-> rd_data_o[6]) else $error("low flag lost");
  irq_enable_a: assert property (
    irq_o |-> $past(en_ff)) else $error("irq without timer enable");
  irq_mask_a: assert property (
    irq_o |-> $past(msk_ff) != 3'h0) else $error("irq while all masked");
  mask_drop_a: assert property (
    w_ctl == 1'b0 && wr_i && addr_i == tm2_pkg::OFS_IRQ_MASK
    && wr_data_i == 8'h00 |-> ##2 !irq_o) else $error("irq kept");
  count_halt_a: assert property (
    rh_ff && ok_ff |-> rd_data_o == hv_ff) else $error("count moved");
  cover property ($rose(irq_o));
  cover property (rh_ff && ok_ff);
  cover property (rc_ff && rd_data_o[7]);
endmodule

// [bench/tb_tm2_timer.sv]
// Purpose: directed register-level test of the timer2 block
// Assumes: count_tick_i tied high, so every clock is a count step
// Notes: reads are taken 1 ns after the edge that answers them
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
bind tm2_timer tm2_timer_sva u_sva (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .count_tick_i(count_tick_i),
  .capture_input_pin_i(capture_input_pin_i), .rd_data_o(rd_data_o),
  .irq_o(irq_o));
module tb_tm2_timer;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
  logic irq;
  int fails = 0, comparisons = 0, cyc = 0;
  tm2_timer DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .count_tick_i(1'b1),
    .capture_input_pin_i(pin), .rd_data_o(rdata), .irq_o(irq));
  initial forever #2 clock_i = ~clock_i;
  ////////////////////////////////////////
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rdd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic expr(input logic [7:0] a, input logic [7:0] e);
    rdd(a, v);
    `CHK(v, e)
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a hang costs a mismatch; the whole run needs about 110 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      conclude();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    wrr(tm2_pkg::OFS_CONTROL, 8'h03);
    expr(tm2_pkg::OFS_CONTROL, 8'h01);
    expr(tm2_pkg::OFS_COUNT_LO, tm2_pkg::BYTE_RST);
    expr(tm2_pkg::OFS_RELOAD_LO, tm2_pkg::BYTE_RST);
    expr(8'h20, 8'h00);
    $display("test reset done");
    wrr(tm2_pkg::OFS_RELOAD_LO, 8'h10);
    wrr(tm2_pkg::OFS_RELOAD_HI, 8'h80);
    wrr(tm2_pkg::OFS_COUNT_LO, 8'hFE);
    wrr(tm2_pkg::OFS_COUNT_HI, 8'hFF);
    wrr(tm2_pkg::OFS_IRQ_CONFIG, 8'h01);
    wrr(tm2_pkg::OFS_IRQ_MASK, 8'h07);
    wrr(tm2_pkg::OFS_CONTROL, 8'h04);
    // one step to 0xffff, then the wrap; the flag-clearing stop lands on it
    wrr(tm2_pkg::OFS_CONTROL, 8'h00);
    expr(tm2_pkg::OFS_COUNT_LO, 8'h10);
    expr(tm2_pkg::OFS_COUNT_HI, 8'h80);
    expr(tm2_pkg::OFS_CONTROL, 8'hC0);
    `CHK(irq, 1'b1)
    expr(tm2_pkg::OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 `CHK(irq, 1'b0)
    expr(tm2_pkg::OFS_CONTROL, 8'hC0);
    expr(tm2_pkg::OFS_COUNT_HI, 8'h80);
    wrr(tm2_pkg::OFS_CONTROL, 8'h00);
    expr(tm2_pkg::OFS_CONTROL, 8'h00);
    $display("test wide mode done");
    wrr(tm2_pkg::OFS_RELOAD_LO, 8'h20);
    wrr(tm2_pkg::OFS_RELOAD_HI, 8'h30);
    wrr(tm2_pkg::OFS_COUNT_LO, 8'hFE);
    wrr(tm2_pkg::OFS_COUNT_HI, 8'h50);
    wrr(tm2_pkg::OFS_IRQ_MASK, 8'h02);
    wrr(tm2_pkg::OFS_CONTROL, 8'h28);
    expr(tm2_pkg::OFS_COUNT_HI, 8'h50);
    expr(tm2_pkg::OFS_CONTROL, 8'h68);
    `CHK(irq, 1'b1)
    expr(tm2_pkg::OFS_IRQ_STATUS, 8'h02);
    wrr(tm2_pkg::OFS_COUNT_HI, 8'hFE);
    wrr(tm2_pkg::OFS_CONTROL, 8'h2C);
    wrr(tm2_pkg::OFS_CONTROL, 8'h28);
    expr(tm2_pkg::OFS_COUNT_HI, 8'h30);
    rdd(tm2_pkg::OFS_CONTROL, v);
    `CHK(v[7], 1'b1)
    $display("test split mode done");
    wrr(tm2_pkg::OFS_CONTROL, 8'h00);
    wrr(tm2_pkg::OFS_COUNT_LO, 8'h34);
    wrr(tm2_pkg::OFS_COUNT_HI, 8'h12);
    wrr(tm2_pkg::OFS_IRQ_MASK, 8'h04);
    rdd(tm2_pkg::OFS_IRQ_STATUS, v);
    @(posedge clock_i);
    pin <= 1'b0;
    @(posedge clock_i);
    pin <= 1'b1;
    expr(tm2_pkg::OFS_RELOAD_LO, 8'h20);
    wrr(tm2_pkg::OFS_CONTROL, 8'h10);
    pin <= 1'b0;
    expr(tm2_pkg::OFS_RELOAD_LO, 8'h34);
    expr(tm2_pkg::OFS_RELOAD_HI, 8'h12);
    `CHK(irq, 1'b1)
    wrr(tm2_pkg::OFS_IRQ_MASK, 8'h00);
    expr(tm2_pkg::OFS_IRQ_STATUS, 8'h04);
    `CHK(irq, 1'b0)
    $display("test capture done");
    conclude();
  end
endmodule
